// file: inc/rcs_defs.vh
// constants of the remote command and status unit
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH
// apb register byte offsets
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_ATTEN 8'h08
`define REG_CONTROL 8'h0C
// reset values and limits
`define MASK_RESET 8'hC0
`define ATTEN_MAX 5'd23
`define TRIG_MAX 7'd71
`define BYTE_MAX 32'h000000FF
`define BOOL_MAX 32'h00000001
// status byte bit positions
`define BIT_READY 0
`define BIT_REJECT 1
`define BIT_NOT_CALIBRATED_LAMP 2
`define BIT_PWRON 3
`define BIT_VALID 4
`define BIT_RQS 6
`define BIT_FRONT 7
// accumulated error code bits
`define ERR_SYNTAX 2'h1
`define ERR_RANGE 2'h2
// characters
`define CH_LF 8'h0A
`define CH_SPACE 8'h20
`define CH_COMMA 8'h2C
`define CH_DOT 8'h2E
`define CH_SEMI 8'h3B
`define CH_X 8'h58
`define CH_M 8'h4D
`define CH_Z 8'h5A
// command codes
`define CMD_NONE 5'h00
`define CMD_READ_BYTE 5'h01
`define CMD_READ_WORD 5'h02
`define CMD_DEF_WADDR 5'h03
`define CMD_WRITE_BYTE 5'h04
`define CMD_WRITE_WORD 5'h05
`define CMD_ATTEN_QUERY 5'h06
`define CMD_SET_ATTEN 5'h07
`define CMD_SYNTH_FREQ 5'h08
`define CMD_RF_SWITCH 5'h09
`define CMD_MASK_SET 5'h0A
`define CMD_MASK_QUERY 5'h0B
`define CMD_ALERT_MODE 5'h0C
`define CMD_CONFIG_TRIG 5'h0D
`define CMD_FIRE_TRIG 5'h0E
`define CMD_ERR_QUERY 5'h0F
`define CMD_CLEAR_ERR 5'h10
`define CMD_FULL_RESET 5'h11
`endif

// file: verilog/remote_command_status_unit.v
// remote command interpreter with service-request status and stored trigger buffer
`timescale 1ns/1ps
`include "rcs_defs.vh"

module remote_command_status_unit #(
  parameter IN_DEPTH = 16,
  parameter IN_AW = 4,
  parameter MEM_AW = 8
) (
  input wire core_clk, // 50 MHz clock
  input wire arst_n, // async reset, active low
  input wire [7:0] paddr, // apb address
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error on unmapped address
  input wire [7:0] in_data, // bus input byte
  input wire in_end, // byte is last of a string
  input wire in_valid, // input byte offered
  output wire in_ready, // input buffer has room
  input wire dev_clear, // device or selected device clear pulse
  input wire group_trigger, // group execute trigger pulse
  input wire spoll_req, // serial poll pulse
  output reg [7:0] spoll_byte, // serial poll response
  output reg [7:0] out_data, // reply byte
  output reg out_valid, // reply byte offered
  input wire out_ready, // reply byte accepted
  output reg srq, // service request line
  input wire rf_settled, // async: rf output settled
  input wire not_calibrated_lamp, // async: not_calibrated_lamp indicator lit
  input wire front_panel_set, // special function 07 pulse
  input wire front_panel_clear, // special function 08 pulse
  output reg [4:0] atten_level, // attenuator setting
  output reg atten_load, // attenuator load pulse
  output reg [31:0] synth_freq, // synthesizer frequency, kHz
  output reg synth_load // synthesizer load pulse
);

  localparam [7:0] S_HDR1 = 8'h01;
  localparam [7:0] S_HDR2 = 8'h02;
  localparam [7:0] S_ARG = 8'h04;
  localparam [7:0] S_SUFX = 8'h08;
  localparam [7:0] S_CT = 8'h10;
  localparam [7:0] S_SKIP = 8'h20;
  localparam [7:0] S_CONV = 8'h40;
  localparam [7:0] S_REPLY = 8'h80;
  localparam [IN_AW:0] FULL_CNT = IN_DEPTH[IN_AW:0];
  localparam [31:0] MEM_TOP = (1 << MEM_AW) - 1;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [4:0] digit_of;
    input [7:0] c;
    input hex;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        digit_of = {1'b1, c[3:0]};
      else if (hex && c >= 8'h41 && c <= 8'h46)
        digit_of = {1'b1, c[3:0] + 4'h9};
      else
        digit_of = 5'h00;
    end
  endfunction

  function [7:0] ascii_of;
    input [3:0] d;
    begin
      ascii_of = (d < 4'hA) ? {4'h3, d} : {4'h4, d - 4'h9};
    end
  endfunction

  function [4:0] decode_hdr;
    input [15:0] h;
    begin
      case (h)
        16'h5242: decode_hdr = `CMD_READ_BYTE;
        16'h5257: decode_hdr = `CMD_READ_WORD;
        16'h4457: decode_hdr = `CMD_DEF_WADDR;
        16'h5742: decode_hdr = `CMD_WRITE_BYTE;
        16'h5757: decode_hdr = `CMD_WRITE_WORD;
        16'h5841: decode_hdr = `CMD_ATTEN_QUERY;
        16'h5842: decode_hdr = `CMD_SET_ATTEN;
        16'h5844: decode_hdr = `CMD_SYNTH_FREQ;
        16'h5852: decode_hdr = `CMD_RF_SWITCH;
        16'h534D: decode_hdr = `CMD_MASK_SET;
        16'h494D: decode_hdr = `CMD_MASK_QUERY;
        16'h5846: decode_hdr = `CMD_ALERT_MODE;
        16'h4354: decode_hdr = `CMD_CONFIG_TRIG;
        16'h5452: decode_hdr = `CMD_FIRE_TRIG;
        16'h4952: decode_hdr = `CMD_ERR_QUERY;
        16'h4345: decode_hdr = `CMD_CLEAR_ERR;
        16'h434C: decode_hdr = `CMD_FULL_RESET;
        default: decode_hdr = `CMD_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  reg [8:0] fifo_mem [0:IN_DEPTH-1];
  reg [7:0] peek_mem [0:(1<<MEM_AW)-1];
  reg [7:0] trig_mem [0:70];
  reg [7:0] rpl_mem [0:7];
  reg [IN_AW-1:0] wr_ptr;
  reg [IN_AW-1:0] rd_ptr;
  reg [IN_AW:0] fifo_cnt;
  reg [7:0] state;
  reg [4:0] cmd;
  reg [7:0] hdr_c1;
  reg [31:0] arg;
  reg arg_seen;
  reg arg_hex;
  reg arg_frac;
  reg arg_done;
  reg [1:0] frac_n;
  reg sufx_n;
  reg [MEM_AW-1:0] wr_addr;
  reg [4:0] atten_saved;
  reg rf_off;
  reg [7:0] mask;
  reg alert_mode;
  reg [6:0] trig_len;
  reg [6:0] trig_idx;
  reg trig_run;
  reg trig_pend;
  reg [15:0] rpl_val;
  reg rpl_hex;
  reg [3:0] rpl_n;
  reg [1:0] err;
  reg [1:0] err_hit;
  reg err_clr;
  reg alert_evt;
  reg alert_fp;
  reg front_fp;
  reg pwron;
  reg rqs;
  reg [6:0] pend_prev;
  reg settled_s1, settled_s2, not_calibrated_lamp_s1, not_calibrated_lamp_s2;

  // ----------------------------------------
  // character source
  // ----------------------------------------
  wire st_hdr1 = state[0];
  wire st_arg = state[2];
  wire trig_start = st_hdr1 & ~trig_run & trig_pend;
  wire src_valid = trig_run | (fifo_cnt != {(IN_AW+1){1'b0}});
  wire trig_tail = trig_idx == trig_len;
  wire [8:0] fifo_head = fifo_mem[rd_ptr];
  wire [7:0] ch = trig_run ? (trig_tail ? `CH_LF : trig_mem[trig_idx]) : fifo_head[7:0];
  wire ch_end = trig_run ? trig_tail : fifo_head[8];
  wire ch_term = ch_end | (ch == `CH_LF);
  wire [4:0] dv = digit_of(ch, arg_hex);
  wire is_x = (ch == `CH_X) & ~arg_seen & ~arg_hex;
  wire is_dot = (ch == `CH_DOT) & (cmd == `CMD_SYNTH_FREQ) & ~arg_frac & ~arg_hex;
  wire arg_char = dv[4] | is_x | is_dot;
  wire take = src_valid & ~trig_start & (|(state & 8'h3B) | (st_arg & arg_char & ~arg_done));
  wire pop = take & ~trig_run;
  wire push = in_valid & in_ready;
  wire [31:0] arg_dec = {arg[28:0], 3'b000} + {arg[30:0], 1'b0} + {28'h0, dv[3:0]};
  wire [31:0] arg_next = arg_hex ? {arg[27:0], dv[3:0]} : arg_dec;
  wire [4:0] hdr_code = decode_hdr({hdr_c1, ch});
  wire [MEM_AW-1:0] loc = arg[MEM_AW-1:0];
  wire [MEM_AW-1:0] loc_nx = loc + 1'b1;
  wire [15:0] rpl_rem = rpl_val % 16'd10;
  wire [15:0] rpl_quo = rpl_val / 16'd10;
  wire [3:0] rpl_dig = rpl_hex ? rpl_val[3:0] : rpl_rem[3:0];

  // ----------------------------------------
  // status byte and service request
  // ----------------------------------------
  // ready flag
  wire ready = ~src_valid & st_hdr1 & ~trig_pend & ~out_valid;
  wire reject = |err;
  wire [7:0] status = {front_fp | alert_fp, rqs, 1'b0, settled_s2, pwron, not_calibrated_lamp_s2, reject, ready};
  wire [6:0] pending = mask[6:0] & {status[7], 1'b0, status[4:0]};
  wire [6:0] pend_now = {pending[6] | (mask[7] & status[7]), pending[5:0]};

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  wire apb_hit = (paddr == `REG_STATUS) | (paddr == `REG_MASK) |
                 (paddr == `REG_ATTEN) | (paddr == `REG_CONTROL);
  wire apb_wr = psel & penable & pwrite & apb_hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~apb_hit;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      case (paddr)
        `REG_STATUS: prdata <= {22'h0, err, status};
        `REG_MASK: prdata <= {24'h0, mask};
        `REG_ATTEN: prdata <= {27'h0, atten_level};
        `REG_CONTROL: prdata <= {31'h0, alert_mode};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  // full buffer refuses bytes
  assign in_ready = fifo_cnt != FULL_CNT;

  always @(posedge core_clk) begin
    if (push)
      fifo_mem[wr_ptr] <= {in_end, in_data};
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= {IN_AW{1'b0}};
      rd_ptr <= {IN_AW{1'b0}};
      fifo_cnt <= {(IN_AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        fifo_cnt <= fifo_cnt + 1'b1;
      else if (pop && !push)
        fifo_cnt <= fifo_cnt - 1'b1;
    end
  end

  // ----------------------------------------
  // synchronisers, errors, service request
  // ----------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      settled_s1 <= 1'b0;
      settled_s2 <= 1'b0;
      not_calibrated_lamp_s1 <= 1'b0;
      not_calibrated_lamp_s2 <= 1'b0;
      err <= 2'h0;
      pwron <= 1'b1;
      front_fp <= 1'b0;
      alert_fp <= 1'b0;
      rqs <= 1'b0;
      srq <= 1'b0;
      pend_prev <= 7'h00;
      spoll_byte <= 8'h00;
    end else begin
      settled_s1 <= rf_settled;
      settled_s2 <= settled_s1;
      not_calibrated_lamp_s1 <= not_calibrated_lamp;
      not_calibrated_lamp_s2 <= not_calibrated_lamp_s1;
      // accumulate, a new error wins over a clear
      err <= ((err_clr | dev_clear) ? 2'h0 : err) | err_hit;
      if (front_panel_clear)
        pwron <= 1'b0;
      front_fp <= front_panel_set | (front_fp & ~front_panel_clear);
      alert_fp <= alert_evt | (alert_fp & ~spoll_req);
      pend_prev <= pend_now;
      // set on new masked reason, clear when gone or polled
      if ((|(pend_now & ~pend_prev)) || alert_evt)
        rqs <= 1'b1;
      else if (spoll_req || (pend_now == 7'h00 && !alert_fp))
        rqs <= 1'b0;
      srq <= rqs;
      if (spoll_req)
        spoll_byte <= status;
    end
  end

  // ----------------------------------------
  // command execution
  // ----------------------------------------
  task syn_err;
    begin
      err_hit <= `ERR_SYNTAX;
      state <= ch_term ? S_HDR1 : S_SKIP;
    end
  endtask

  task start_reply;
    input [15:0] v;
    input h;
    begin
      rpl_val <= v;
      rpl_hex <= h;
      rpl_mem[0] <= `CH_LF;
      rpl_n <= 4'h1;
      state <= S_CONV;
    end
  endtask

  task exec_cmd;
    input [4:0] c;
    begin
      alert_evt <= alert_mode;
      state <= S_HDR1;
      case (c)
        `CMD_READ_BYTE, `CMD_READ_WORD: begin
          // bad location recorded, parsing goes on
          if (arg > MEM_TOP)
            err_hit <= `ERR_RANGE;
          else if (c == `CMD_READ_BYTE)
            start_reply({8'h00, peek_mem[loc]}, arg_hex);
          else
            start_reply({peek_mem[loc], peek_mem[loc_nx]}, arg_hex);
        end
        `CMD_DEF_WADDR: begin
          if (arg > MEM_TOP)
            err_hit <= `ERR_RANGE;
          else
            wr_addr <= loc;
        end
        `CMD_WRITE_BYTE: peek_mem[wr_addr] <= arg[7:0];
        `CMD_WRITE_WORD: begin
          peek_mem[wr_addr] <= arg[15:8];
          peek_mem[wr_addr + 1'b1] <= arg[7:0];
        end
        `CMD_ATTEN_QUERY: start_reply({11'h0, atten_level}, 1'b0);
        // range check on 6 dB steps
        `CMD_SET_ATTEN: begin
          if (arg > {27'h0, `ATTEN_MAX}) begin
            err_hit <= `ERR_RANGE;
          end else begin
            atten_level <= arg[4:0];
            atten_load <= 1'b1;
          end
        end
        // switch off saves, switch on restores
        `CMD_RF_SWITCH: begin
          if (arg > `BOOL_MAX) begin
            syn_err;
          end else if (!arg[0]) begin
            if (!rf_off)
              atten_saved <= atten_level;
            rf_off <= 1'b1;
            atten_level <= `ATTEN_MAX;
            atten_load <= 1'b1;
          end else if (rf_off) begin
            rf_off <= 1'b0;
            atten_level <= atten_saved;
            atten_load <= 1'b1;
          end
        end
        `CMD_MASK_SET: begin
          if (arg > `BYTE_MAX)
            err_hit <= `ERR_RANGE;
          else
            mask <= arg[7:0];
        end
        `CMD_MASK_QUERY: start_reply({8'h00, mask}, 1'b0);
        `CMD_ALERT_MODE: begin
          if (arg > `BOOL_MAX)
            syn_err;
          else
            alert_mode <= arg[0];
        end
        `CMD_CONFIG_TRIG: begin
          trig_len <= 7'h00;
          state <= S_CT;
        end
        // fire stored buffer, not from inside itself
        `CMD_FIRE_TRIG: begin
          if (trig_run)
            err_hit <= `ERR_RANGE;
          else
            trig_pend <= 1'b1;
        end
        `CMD_ERR_QUERY: begin
          start_reply({14'h0, err}, 1'b0);
          err_clr <= 1'b1;
        end
        `CMD_CLEAR_ERR: err_clr <= 1'b1;
        `CMD_FULL_RESET: begin
          err_clr <= 1'b1;
          mask <= `MASK_RESET;
          alert_mode <= 1'b0;
        end
        default: syn_err;
      endcase
    end
  endtask

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_HDR1;
      cmd <= `CMD_NONE;
      hdr_c1 <= 8'h00;
      arg <= 32'h00000000;
      arg_seen <= 1'b0;
      arg_hex <= 1'b0;
      arg_frac <= 1'b0;
      frac_n <= 2'h0;
      sufx_n <= 1'b0;
      arg_done <= 1'b0;
      wr_addr <= {MEM_AW{1'b0}};
      atten_level <= 5'h00;
      atten_saved <= 5'h00;
      atten_load <= 1'b0;
      rf_off <= 1'b0;
      synth_freq <= 32'h00000000;
      synth_load <= 1'b0;
      mask <= `MASK_RESET;
      alert_mode <= 1'b0;
      trig_len <= 7'h00;
      trig_idx <= 7'h00;
      trig_run <= 1'b0;
      trig_pend <= 1'b0;
      rpl_val <= 16'h0000;
      rpl_hex <= 1'b0;
      rpl_n <= 4'h0;
      out_data <= 8'h00;
      out_valid <= 1'b0;
      err_hit <= 2'h0;
      err_clr <= 1'b0;
      alert_evt <= 1'b0;
    end else begin
      atten_load <= 1'b0;
      synth_load <= 1'b0;
      err_hit <= 2'h0;
      err_clr <= 1'b0;
      alert_evt <= 1'b0;
      if (dev_clear)
        trig_pend <= 1'b0;
      if (trig_start) begin
        trig_pend <= 1'b0;
        trig_run <= 1'b1;
        trig_idx <= 7'h00;
      end else if (take && trig_run) begin
        if (trig_tail)
          trig_run <= 1'b0;
        else
          trig_idx <= trig_idx + 1'b1;
      end
      if (apb_wr && paddr == `REG_MASK)
        mask <= pwdata[7:0];
      if (apb_wr && paddr == `REG_CONTROL)
        alert_mode <= pwdata[0];
      case (state)
        S_HDR1: begin
          if (take && ch >= 8'h41 && ch <= 8'h5A && !ch_end) begin
            hdr_c1 <= ch;
            state <= S_HDR2;
          end else if (take && !ch_term && ch != `CH_SEMI && ch != `CH_SPACE &&
                       ch != `CH_COMMA) begin
            syn_err;
          end
        end
        S_HDR2: begin
          if (take) begin
            cmd <= hdr_code;
            arg <= 32'h00000000;
            arg_seen <= 1'b0;
            arg_hex <= 1'b0;
            arg_frac <= 1'b0;
            frac_n <= 2'h0;
            if (hdr_code == `CMD_NONE)
              syn_err;
            else if (hdr_code >= `CMD_ATTEN_QUERY && hdr_code != `CMD_SET_ATTEN &&
                     hdr_code != `CMD_SYNTH_FREQ && hdr_code != `CMD_RF_SWITCH &&
                     hdr_code != `CMD_MASK_SET && hdr_code != `CMD_ALERT_MODE)
              exec_cmd(hdr_code);
            else if (ch_end)
              syn_err;
            else
              state <= S_ARG;
          end
        end
        S_ARG: begin
          // argument closed by a string end: run it once arg holds the last digit
          if (arg_done) begin
            arg_done <= 1'b0;
            exec_cmd(cmd);
          end else if (take) begin
            if (is_x)
              arg_hex <= 1'b1;
            else if (is_dot)
              arg_frac <= 1'b1;
            else if (!arg_frac || frac_n != 2'h3) begin
              arg <= arg_next;
              arg_seen <= 1'b1;
              if (arg_frac)
                frac_n <= frac_n + 1'b1;
            end
            if (ch_end) begin
              if (!(arg_seen || dv[4]) || cmd == `CMD_SYNTH_FREQ)
                syn_err;
              else
                arg_done <= 1'b1;
            end
          end else if (src_valid && !trig_start) begin
            if (!arg_seen)
              syn_err;
            else if (cmd == `CMD_SYNTH_FREQ) begin
              sufx_n <= 1'b0;
              state <= S_SUFX;
            end else
              exec_cmd(cmd);
          end
        end
        // frequency in MHz with up to three decimals, sent out as kHz
        S_SUFX: begin
          if (take) begin
            if (ch != (sufx_n ? `CH_Z : `CH_M) || (ch_end && !sufx_n)) begin
              syn_err;
            end else if (!sufx_n) begin
              sufx_n <= 1'b1;
            end else begin
              alert_evt <= alert_mode;
              synth_load <= 1'b1;
              state <= S_HDR1;
              case (frac_n)
                2'h0: synth_freq <= arg * 32'd1000;
                2'h1: synth_freq <= arg * 32'd100;
                2'h2: synth_freq <= arg * 32'd10;
                default: synth_freq <= arg;
              endcase
            end
          end
        end
        S_CT: begin
          if (take) begin
            if (ch_term)
              state <= S_HDR1;
            else if (trig_run || trig_len == `TRIG_MAX)
              syn_err;
            else begin
              trig_mem[trig_len] <= ch;
              trig_len <= trig_len + 1'b1;
            end
          end
        end
        S_SKIP: begin
          if (take && ch_term)
            state <= S_HDR1;
        end
        // digits are built last first, then sent from the top down
        S_CONV: begin
          if (rpl_val == 16'h0000 && rpl_n != 4'h1) begin
            if (rpl_hex) begin
              rpl_mem[rpl_n[2:0]] <= `CH_X;
              rpl_n <= rpl_n + 1'b1;
              rpl_hex <= 1'b0;
            end else
              state <= S_REPLY;
          end else begin
            rpl_mem[rpl_n[2:0]] <= ascii_of(rpl_dig);
            rpl_val <= rpl_hex ? {4'h0, rpl_val[15:4]} : rpl_quo;
            rpl_n <= rpl_n + 1'b1;
          end
        end
        S_REPLY: begin
          if (!out_valid || out_ready) begin
            if (rpl_n == 4'h0) begin
              out_valid <= 1'b0;
              state <= S_HDR1;
            end else begin
              out_data <= rpl_mem[rpl_n[2:0] - 3'h1];
              out_valid <= 1'b1;
              rpl_n <= rpl_n - 1'b1;
            end
          end
        end
        default: state <= S_HDR1;
      endcase
      // a trigger arriving with a clear or a start is still kept
      if (group_trigger)
        trig_pend <= 1'b1;
    end
  end

endmodule

// file: test/rcs_properties.sv
// port assertions of the remote command unit
`timescale 1ns/1ps
module rcs_properties (
  input wire core_clk, // clock
  input wire arst_n, // reset, active low
  input wire [7:0] paddr, // apb address
  input wire psel, // apb select
  input wire penable, // apb access
  input wire [31:0] prdata, // apb read data
  input wire pslverr, // apb error
  input wire [7:0] out_data, // reply byte
  input wire out_valid, // reply offered
  input wire out_ready, // reply taken
  input wire [7:0] spoll_byte, // poll response
  input wire [4:0] atten_level, // attenuator
  input wire atten_load, // attenuator pulse
  input wire synth_load // synthesizer pulse
);
  // ----
  // properties
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire acc = psel && penable;
  wire map = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
  chk_unmapped_err: assert property (acc && !map |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acc && map |-> !pslverr)
    else $error("mapped access refused");
  chk_atten_range: assert property (atten_level <= 5'h17)
    else $error("attenuation above range");
  chk_poll_unused: assert property (spoll_byte[5] == 1'b0)
    else $error("unused poll bit set");
  chk_reply_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("reply byte dropped");
  chk_atten_cause: assert property ($changed(atten_level) |-> atten_load)
    else $error("attenuator changed without load");
  chk_atten_pulse: assert property (atten_load |=> !atten_load)
    else $error("attenuator load too long");
  chk_synth_pulse: assert property (synth_load |=> !synth_load)
    else $error("synthesizer load too long");
endmodule
bind remote_command_status_unit rcs_properties i_rcs_properties (.*);

// file: test/bus_controller_model.sv
// bus controller model: sends command bytes, collects reply bytes
`timescale 1ns/1ps
module bus_controller_model (
  input wire core_clk, // clock
  output reg [7:0] in_data, // command byte
  output reg in_end, // last byte flag
  output reg in_valid, // byte offered
  input wire in_ready, // buffer has room
  input wire [7:0] out_data, // reply byte
  input wire out_valid, // reply offered
  output reg out_ready // reply taken
);
  // ----
  // model
  // ----
  string rx = "";
  initial {in_data, in_end, in_valid, out_ready} = 11'h0;
  // slow reader: half the cycles stall, so replies must hold
  always @(posedge core_clk) begin
    out_ready <= !out_ready;
    if (out_valid && out_ready)
      rx = $sformatf("%s%c", rx, out_data);
  end
  task send(input string s, input bit t);
    for (int i = 0; i < s.len(); i++) begin
      in_data <= s[i];
      in_end <= t && i == s.len() - 1;
      in_valid <= 1'b1;
      @(posedge core_clk iff in_ready);
    end
    in_valid <= 1'b0;
    // released line must not keep the last value
    in_data <= ~in_data;
    in_end <= ~in_end;
  endtask
endmodule

// file: test/test_remote_command_status_unit.sv
// self-checking bench of the remote command unit
`timescale 1ns/1ps
module test_remote_command_status_unit;
  logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic dev_clear = 0, group_trigger = 0, spoll_req = 0, rf_settled = 0;
  logic not_calibrated_lamp = 0, front_panel_set = 0, front_panel_clear = 0;
  logic [7:0] paddr = 0, in_data, out_data, spoll_byte;
  logic [31:0] pwdata = 0, prdata, rd, synth_freq;
  logic [4:0] atten_level;
  logic pready, pslverr, in_end, in_valid, in_ready, out_valid, out_ready;
  logic srq, atten_load, synth_load;
  int num_errors = 0, checked = 0, cycles = 0, stalls = 0;
  remote_command_status_unit i_remote_command_status_unit (.*);
  bus_controller_model i_bus_controller_model (.*);
  // ----
  // helpers
  // ----
  initial forever #10 core_clk = ~core_clk;
  task chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // status lags the last byte by a few cycles
  task idle;
    rd = 0;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 200 && rd[0] !== 1'b1; i++)
      apb(0, 8'h00, 0);
    chk(rd[0], 1'b1);
  endtask
  task cmd(input string s, e = "", input bit t = 0);
    i_bus_controller_model.rx = "";
    i_bus_controller_model.send(s, t);
    idle;
    checked++;
    if (i_bus_controller_model.rx != e) begin
      num_errors++;
      $display("wrong value at %0t: bad reply", $time);
    end
  endtask
  // one-cycle pulse: 0 device clear, 1 group trigger, 2 serial poll
  task pulse(input int k);
    {spoll_req, group_trigger, dev_clear} <= 3'h1 << k;
    @(posedge core_clk);
    {spoll_req, group_trigger, dev_clear} <= 3'h0;
    idle;
  endtask
  task end_of_test;
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_regs;
    apb(0, 8'h04, 0);
    chk(rd, 32'h000000C0);
    apb(0, 8'h00, 0);
    chk(rd[3], 1'b1);
    apb(1, 8'h0C, 32'h1);
    apb(0, 8'h0C, 0);
    chk(rd, 32'h1);
    apb(1, 8'h0C, 0);
    apb(0, 8'h10, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask
  task t_cmds;
    cmd("TR\n");
    chk(atten_level, 5'h00);
    cmd("SM2\n");
    apb(0, 8'h04, 0);
    chk(rd, 32'h2);
    cmd("IM\n", "2\n");
    cmd("XB5\n");
    chk(atten_level, 5'h05);
    cmd("XR0\n");
    chk(atten_level, 5'h17);
    cmd("XR1;XA\n", "5\n");
  endtask
  task t_errs;
    cmd("XB24;XB9\n");
    chk(atten_level, 5'h09);
    chk(rd[1], 1'b1);
    chk(srq, 1'b1);
    cmd("IR\n", "2\n");
    chk(srq, 1'b0);
    cmd("QQ1;XB3\n");
    chk(rd[9:8], 2'h1);
    chk(atten_level, 5'h09);
    pulse(0);
    chk(rd[9:8], 2'h0);
  endtask
  task t_mem_trig;
    cmd("DWX10;WB171\n");
    cmd("RBX10\n", "XAB\n");
    cmd("RB16\n", "171\n");
    cmd("CTXB7\n");
    chk(atten_level, 5'h09);
    cmd("TR\n");
    chk(atten_level, 5'h07);
    cmd("XB1\n");
    pulse(1);
    chk(atten_level, 5'h07);
  endtask
  task t_modes;
    cmd("DW32;WW4660;RW32\n", "4660\n");
    cmd("XF1;XF0\n");
    chk(srq, 1'b1);
    pulse(2);
    chk(spoll_byte[7:6], 2'h3);
    chk(srq, 1'b0);
    cmd("QQ\n");
    chk(rd[8], 1'b1);
    cmd("CE\n");
    chk(rd[9:8], 2'h0);
    cmd("CL\n");
    apb(0, 8'h04, 0);
    chk(rd, 32'h000000C0);
  endtask
  task t_full;
    string s;
    s = "CT";
    repeat (17) s = {s, "XB2;"};
    cmd({s, "XB7\n"});
    cmd("TR;XB4;XB4;XB4;XB4;XB5\n");
    chk(stalls > 0, 1'b1);
    chk(atten_level, 5'h05);
    cmd("XB6", "", 1);
    chk(atten_level, 5'h06);
  endtask
  task t_synth_poll;
    rf_settled <= 1'b1;
    cmd("XD12.5MZ\n");
    chk(synth_freq, 32'h000030D4);
    front_panel_set <= 1'b1;
    @(posedge core_clk);
    front_panel_set <= 1'b0;
    pulse(2);
    chk(spoll_byte & 8'hB8, 8'h98);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs;
    t_cmds;
    t_errs;
    t_mem_trig;
    t_modes;
    t_synth_poll;
    t_full;
    end_of_test;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (in_valid && !in_ready)
      stalls++;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test;
    end
  end
endmodule
